// ===== pkg/idec_pkg.sv
// constants and types shared by the instruction decode and execute block
package idec_pkg;
  localparam int INSTR_W = 14;
  localparam int OSC_PER_CYCLE = 4; // oscillator periods in one instruction cycle
  localparam logic [1:0] Q_LAST = 2'h3; // last quarter of a cycle
  // instruction classes in the two top bits
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // fixed control words under the all-zero prefix
  localparam logic [7:0] CW_RETURN = 8'h08;
  localparam logic [7:0] CW_RETURN_INT = 8'h09;
  localparam logic [7:0] CW_STANDBY = 8'h63;
  localparam logic [7:0] CW_CLEAR_WDT = 8'h64;
  localparam logic [7:0] CW_NOP_MASK = 8'h9f; // bits 6:5 are don't-care
  // status flag update mask {carry, digit carry, zero}
  localparam logic [2:0] FLAG_NONE = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_C = 3'h4;
  localparam logic [2:0] FLAG_ALL = 3'h7;
  // register map, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_LAST = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [5:0] {
    op_nop, op_move_accum_to_file, op_clear_file, op_clear_accum, op_file_minus_accum,
    op_decrement_file, op_or_accum_into_file, op_and_accum_file, op_exclusive_or_accum_file,
    op_add_accum_file, op_move_file, op_complement_file, op_increment_file,
    op_decrement_skip_zero, op_rotate_right_via_carry, op_rotate_left_via_carry,
    op_swap_nibbles, op_increment_skip_zero, op_bit_clear, op_bit_set,
    op_bit_test_skip_clear, op_bit_test_skip_set, op_call, op_jump_absolute,
    op_move_literal, op_return_with_literal, op_or_literal_accum, op_and_literal_accum,
    op_literal_minus_accum, op_add_literal_accum, op_return, op_return_from_int,
    op_standby, op_clear_watchdog
  } op_t;
endpackage : idec_pkg

// ===== hdl/instruction_decode_execute.sv
// instruction decode and execution timing for a 14-bit accumulator instruction set
// Summary of operation
// - one cycle; skips and jumps add nop
// - instruction cycle equals four oscillator periods
// - top two bits pick instruction class
// - seven-bit file address in low bits
// - destination bit picks accumulator or file
// - three-bit field selects bit in file
// - don't-care opcode bits never change decode
// - call and jump carry eleven-bit target, two cycles
// - rotates through carry update carry only
// - or and xor with file update zero only
// - decrement/increment skip on zero, no flags
// - bit tests skip with nop when true
// - or literal into accumulator, zero flag, one cycle
// - return with literal loads accumulator, two cycles
// - literal minus accumulator updates carry, digit, zero
// - standby enters low power unless wake is high in the same cycle, sets timeout flag, clears powerdown flag
// - port read-modify-write takes pin levels
// - timer count write clears assigned prescaler
module instruction_decode_execute #(
  parameter logic [6:0] PCL_ADDR = 7'h02, // program counter low byte in the file
  parameter logic [6:0] TIMER_ADDR = 7'h01, // timer_zero_count in the file
  parameter logic [6:0] PORT_A_ADDR = 7'h05,
  parameter logic [6:0] PORT_B_ADDR = 7'h06
) (
  input wire logic sys_clk, // 50 MHz oscillator clock
  input wire logic arst_n, // async reset, active low
  input wire logic [13:0] instr_word, // word from program memory
  input wire logic [7:0] file_data, // operand read at the instruction's file address
  input wire logic prescaler_to_timer, // prescaler assigned to the timer
  input wire logic wake, // wake-up event from standby
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hsel, // ahb select
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response
  output logic fetch_strobe, // pulse: sample next instruction word
  output logic exec_strobe, // pulse: decoded outputs new
  output idec_pkg::op_t op_reg, // decoded operation
  output logic [6:0] file_addr_reg, // file operand address
  output logic dest_file_reg, // 1 result to file, 0 to accumulator
  output logic [2:0] bit_sel_reg, // bit position
  output logic [7:0] literal_reg, // eight-bit literal
  output logic [10:0] target_reg, // jump or call target
  output logic [2:0] flag_mask_reg, // {c, dc, z} updated
  output logic two_cycle_reg, // instruction takes two cycles
  output logic nop_cycle_reg, // current cycle forced to nop
  output logic read_pins_reg, // take port pins, not latch
  output logic prescaler_clear, // pulse: clear timer prescaler
  output logic wdt_clear, // pulse: clear watchdog
  output logic standby_reg, // core in standby
  output logic timeout_flag_reg, // timeout status flag
  output logic powerdown_flag_reg // powerdown status flag
);
  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_a_reg;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus: zero wait, always okay
  logic run_reg;
  logic [15:0] count_reg;
  logic [13:0] last_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] rd_addr;
  logic bus_take;
  assign bus_take = hsel && hready && (htrans == idec_pkg::HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_addr = haddr[7:0];

  // address phase captured for the write data phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_take && hwrite;
      wr_addr_reg <= rd_addr;
    end
  end

  // control: run enable gates the cycle divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= idec_pkg::CTRL_RESET[0];
    end else if (wr_pend_reg && wr_addr_reg == idec_pkg::OFS_CTRL) begin
      run_reg <= hwdata[0];
    end
  end

  // read data registered in the data phase; unmapped reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      case (rd_addr)
        idec_pkg::OFS_CTRL: hrdata <= {31'h0000_0000, run_reg};
        idec_pkg::OFS_STATUS: hrdata <= {20'h00000, op_reg, standby_reg, timeout_flag_reg,
                                        powerdown_flag_reg, two_cycle_reg, nop_cycle_reg, read_pins_reg};
        idec_pkg::OFS_COUNT: hrdata <= {16'h0000, count_reg};
        idec_pkg::OFS_LAST: hrdata <= {18'h00000, last_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // quarter counter: four oscillator periods per instruction cycle
  logic [1:0] q_reg;
  logic go;
  logic cycle_end;
  assign go = run_reg && !standby_reg;
  assign cycle_end = go && (q_reg == idec_pkg::Q_LAST);
  assign fetch_strobe = go && (q_reg == 2'h0);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= 2'h0;
    end else if (go) begin
      q_reg <= q_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // combinational decode of the word at the end of the cycle
  idec_pkg::op_t op_next;
  logic [2:0] flag_next;
  logic dest_next;
  logic skip_next;
  logic rmw_next;
  logic [1:0] cls;
  logic [3:0] sub;
  logic dbit;
  logic [7:0] low;
  logic [6:0] fa;
  logic [2:0] bsel;
  assign cls = instr_word[13:12];
  assign sub = instr_word[11:8];
  assign dbit = instr_word[7];
  assign low = instr_word[7:0];
  assign fa = instr_word[6:0];
  assign bsel = instr_word[9:7];

  always_comb begin
    op_next = idec_pkg::op_nop;
    flag_next = idec_pkg::FLAG_NONE;
    dest_next = dbit;
    skip_next = 1'b0;
    rmw_next = 1'b1;
    case (cls)
      idec_pkg::CLS_BYTE: begin
        case (sub)
          4'h0: begin
            rmw_next = 1'b0;
            dest_next = dbit;
            if (dbit) op_next = idec_pkg::op_move_accum_to_file;
            else if (low == idec_pkg::CW_RETURN) op_next = idec_pkg::op_return;
            else if (low == idec_pkg::CW_RETURN_INT) op_next = idec_pkg::op_return_from_int;
            else if (low == idec_pkg::CW_STANDBY) op_next = idec_pkg::op_standby;
            else if (low == idec_pkg::CW_CLEAR_WDT) op_next = idec_pkg::op_clear_watchdog;
            else op_next = idec_pkg::op_nop;
          end
          4'h1: begin
            rmw_next = 1'b0;
            op_next = dbit ? idec_pkg::op_clear_file : idec_pkg::op_clear_accum;
            flag_next = idec_pkg::FLAG_Z;
          end
          4'h2: begin op_next = idec_pkg::op_file_minus_accum; flag_next = idec_pkg::FLAG_ALL; end
          4'h3: begin op_next = idec_pkg::op_decrement_file; flag_next = idec_pkg::FLAG_Z; end
          4'h4: begin op_next = idec_pkg::op_or_accum_into_file; flag_next = idec_pkg::FLAG_Z; end
          4'h5: begin op_next = idec_pkg::op_and_accum_file; flag_next = idec_pkg::FLAG_Z; end
          4'h6: begin op_next = idec_pkg::op_exclusive_or_accum_file; flag_next = idec_pkg::FLAG_Z; end
          4'h7: begin op_next = idec_pkg::op_add_accum_file; flag_next = idec_pkg::FLAG_ALL; end
          4'h8: begin op_next = idec_pkg::op_move_file; flag_next = idec_pkg::FLAG_Z; end
          4'h9: begin op_next = idec_pkg::op_complement_file; flag_next = idec_pkg::FLAG_Z; end
          4'ha: begin op_next = idec_pkg::op_increment_file; flag_next = idec_pkg::FLAG_Z; end
          4'hb: begin
            op_next = idec_pkg::op_decrement_skip_zero;
            skip_next = (file_data == 8'h01);
          end
          4'hc: begin op_next = idec_pkg::op_rotate_right_via_carry; flag_next = idec_pkg::FLAG_C; end
          4'hd: begin op_next = idec_pkg::op_rotate_left_via_carry; flag_next = idec_pkg::FLAG_C; end
          4'he: op_next = idec_pkg::op_swap_nibbles;
          4'hf: begin
            op_next = idec_pkg::op_increment_skip_zero;
            skip_next = (file_data == 8'hff);
          end
          default: op_next = idec_pkg::op_nop;
        endcase
        // writing the program counter low byte alters the flow
        if (dest_next && fa == PCL_ADDR && op_next != idec_pkg::op_nop) skip_next = 1'b1;
      end
      idec_pkg::CLS_BIT: begin
        dest_next = 1'b1;
        case (sub[3:2])
          2'h0: op_next = idec_pkg::op_bit_clear;
          2'h1: op_next = idec_pkg::op_bit_set;
          2'h2: begin
            op_next = idec_pkg::op_bit_test_skip_clear;
            dest_next = 1'b0;
            skip_next = !file_data[bsel];
          end
          default: begin
            op_next = idec_pkg::op_bit_test_skip_set;
            dest_next = 1'b0;
            skip_next = file_data[bsel];
          end
        endcase
      end
      idec_pkg::CLS_JUMP: begin
        rmw_next = 1'b0;
        dest_next = 1'b0;
        op_next = sub[3] ? idec_pkg::op_jump_absolute : idec_pkg::op_call;
        skip_next = 1'b1;
      end
      default: begin
        rmw_next = 1'b0;
        dest_next = 1'b0;
        // bits marked don't-care are simply not examined
        if (sub[3:2] == 2'h0) op_next = idec_pkg::op_move_literal;
        else if (sub[3:2] == 2'h1) begin
          op_next = idec_pkg::op_return_with_literal;
          skip_next = 1'b1;
        end else if (sub == 4'h8) begin
          op_next = idec_pkg::op_or_literal_accum;
          flag_next = idec_pkg::FLAG_Z;
        end else if (sub == 4'h9) begin
          op_next = idec_pkg::op_and_literal_accum;
          flag_next = idec_pkg::FLAG_Z;
        end else if (sub[3:1] == 3'h6) begin
          op_next = idec_pkg::op_literal_minus_accum;
          flag_next = idec_pkg::FLAG_ALL;
        end else if (sub[3:1] == 3'h7) begin
          op_next = idec_pkg::op_add_literal_accum;
          flag_next = idec_pkg::FLAG_ALL;
        end else op_next = idec_pkg::op_nop; // unlisted code runs as nop
      end
    endcase
    // returns always change the program counter
    if (op_next == idec_pkg::op_return || op_next == idec_pkg::op_return_from_int) skip_next = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded outputs, loaded once per instruction cycle
  logic pend_nop_reg;
  logic timer_write;
  assign timer_write = dest_next && fa == TIMER_ADDR && cls != idec_pkg::CLS_JUMP && cls != idec_pkg::CLS_LIT;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg <= idec_pkg::op_nop;
      file_addr_reg <= 7'h00;
      dest_file_reg <= 1'b0;
      bit_sel_reg <= 3'h0;
      literal_reg <= 8'h00;
      target_reg <= 11'h000;
      flag_mask_reg <= idec_pkg::FLAG_NONE;
      two_cycle_reg <= 1'b0;
      nop_cycle_reg <= 1'b0;
      read_pins_reg <= 1'b0;
      pend_nop_reg <= 1'b0;
      exec_strobe <= 1'b0;
      prescaler_clear <= 1'b0;
      wdt_clear <= 1'b0;
      last_reg <= 14'h0000;
      count_reg <= 16'h0000;
    end else begin
      exec_strobe <= cycle_end;
      prescaler_clear <= 1'b0;
      wdt_clear <= 1'b0;
      if (cycle_end && pend_nop_reg) begin
        // second cycle of a two-cycle instruction: word discarded
        op_reg <= idec_pkg::op_nop;
        nop_cycle_reg <= 1'b1;
        two_cycle_reg <= 1'b0;
        dest_file_reg <= 1'b0;
        flag_mask_reg <= idec_pkg::FLAG_NONE;
        read_pins_reg <= 1'b0;
        pend_nop_reg <= 1'b0;
      end else if (cycle_end) begin
        op_reg <= op_next;
        file_addr_reg <= fa;
        dest_file_reg <= dest_next;
        bit_sel_reg <= bsel;
        literal_reg <= low;
        target_reg <= instr_word[10:0];
        flag_mask_reg <= flag_next;
        two_cycle_reg <= skip_next;
        nop_cycle_reg <= 1'b0;
        pend_nop_reg <= skip_next;
        read_pins_reg <= rmw_next && (fa == PORT_A_ADDR || fa == PORT_B_ADDR);
        prescaler_clear <= timer_write && prescaler_to_timer;
        wdt_clear <= (op_next == idec_pkg::op_clear_watchdog || op_next == idec_pkg::op_standby);
        last_reg <= instr_word;
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // standby and the timeout/powerdown flags; wake wins over a new entry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_reg <= 1'b0;
      timeout_flag_reg <= 1'b1;
      powerdown_flag_reg <= 1'b1;
    end else if (cycle_end && !pend_nop_reg && op_next == idec_pkg::op_standby) begin
      standby_reg <= !wake;
      timeout_flag_reg <= 1'b1;
      powerdown_flag_reg <= 1'b0;
    end else if (cycle_end && !pend_nop_reg && op_next == idec_pkg::op_clear_watchdog) begin
      timeout_flag_reg <= 1'b1;
      powerdown_flag_reg <= 1'b1;
    end else if (standby_reg && wake) begin
      standby_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_new_exec;
    exec_strobe && !nop_cycle_reg;
  endsequence
  a_quarter_rate: assert property (exec_strobe |=> !exec_strobe [*3])
    else $error("instruction cycles closer than four clocks");
  a_two_then_nop: assert property (s_new_exec ##0 two_cycle_reg |-> pend_nop_reg ##1 pend_nop_reg [*3])
    else $error("two-cycle instruction lost its nop cycle");
  a_class_bit: assert property (s_new_exec ##0 ($past(instr_word[13:12]) == idec_pkg::CLS_BIT) |->
    op_reg inside {idec_pkg::op_bit_clear, idec_pkg::op_bit_set, idec_pkg::op_bit_test_skip_clear,
                   idec_pkg::op_bit_test_skip_set})
    else $error("bit class decoded to a non-bit operation");
  a_file_field: assert property (s_new_exec |-> file_addr_reg == $past(instr_word[6:0]))
    else $error("file address not taken from low bits");
  a_dest_bit: assert property (s_new_exec ##0 ($past(instr_word[13:9]) != 5'h00) ##0
    ($past(instr_word[13:12]) == idec_pkg::CLS_BYTE) |-> dest_file_reg == $past(instr_word[7]))
    else $error("destination does not follow d bit");
  a_bit_select: assert property (s_new_exec ##0 ($past(instr_word[13:12]) == idec_pkg::CLS_BIT) |->
    bit_sel_reg == $past(instr_word[9:7]))
    else $error("bit select field wrong");
  a_jump_target: assert property (s_new_exec ##0 ($past(instr_word[13:12]) == idec_pkg::CLS_JUMP) |->
    two_cycle_reg && target_reg == $past(instr_word[10:0]))
    else $error("call or jump target or timing wrong");
  a_rotate_flags: assert property (exec_strobe && (op_reg == idec_pkg::op_rotate_left_via_carry ||
    op_reg == idec_pkg::op_rotate_right_via_carry) |-> flag_mask_reg == idec_pkg::FLAG_C)
    else $error("rotate updates flags other than carry");
  a_skip_zero: assert property (s_new_exec ##0 (op_reg == idec_pkg::op_decrement_skip_zero) |->
    two_cycle_reg == ($past(file_data) == 8'h01 || (dest_file_reg && file_addr_reg == PCL_ADDR)) &&
    flag_mask_reg == idec_pkg::FLAG_NONE)
    else $error("decrement skip decision wrong");
  a_standby_flags: assert property (s_new_exec ##0 (op_reg == idec_pkg::op_standby) |->
    timeout_flag_reg && !powerdown_flag_reg)
    else $error("standby did not update status flags");
  a_prescaler_clr: assert property (prescaler_clear |-> exec_strobe && dest_file_reg &&
    file_addr_reg == TIMER_ADDR)
    else $error("prescaler cleared without a timer write");
endmodule : instruction_decode_execute

// ===== verification/prog_mem.sv
// program memory model feeding instruction words and operands to the decoder
module prog_mem (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic fetch_strobe, // advance to next word
  input wire logic ld_en, // preload strobe
  input wire logic [7:0] ld_addr, // preload address
  input wire logic [21:0] ld_data, // {operand, word}
  output logic [13:0] instr_word, // word to decoder
  output logic [7:0] file_data // operand of that word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [21:0] mem [256];
  logic [7:0] ptr_reg;
  // preload port, used while the core is halted
  always_ff @(posedge sys_clk) begin
    if (ld_en) begin
      mem[ld_addr] <= ld_data;
    end
  end
  // word moves only at the fetch edge, then holds through the cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= 8'h00;
      {file_data, instr_word} <= 22'h3fffff;
    end else if (fetch_strobe) begin
      {file_data, instr_word} <= mem[ptr_reg];
      ptr_reg <= ptr_reg + 8'h01;
    end
  end
endmodule : prog_mem

// ===== verification/instruction_decode_execute_tb.sv
// self-checking bench for the instruction decode and execute block
module instruction_decode_execute_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] MN = idec_pkg::FLAG_NONE;
  localparam logic [2:0] MZ = idec_pkg::FLAG_Z;
  localparam logic [2:0] MC = idec_pkg::FLAG_C;
  localparam logic [2:0] MA = idec_pkg::FLAG_ALL;
  localparam logic [21:0] CORNER [14] = '{22'h000081, 22'h000886, 22'h000064, 22'h004bff, 22'h002800,
    22'h201f88, 22'h002800, 22'h000060, 22'h3f8f8a, 22'h002fff, 22'h002800, 22'h003c5a, 22'h000c81, 22'h0034aa};
  logic sys_clk = 1'b0, arst_n = 1'b0, wake = 1'b0, hwrite = 1'b0, hsel = 1'b0, ld_en = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] ld_addr = 8'h00, fd;
  logic [21:0] ld_data = 22'h0, wq [256];
  logic [13:0] instr_word, w, cw;
  logic [7:0] file_data, literal_reg;
  logic [31:0] hrdata;
  logic hreadyout, hresp, fetch_strobe, exec_strobe, dest_file_reg, two_cycle_reg, nop_cycle_reg;
  logic read_pins_reg, prescaler_clear, wdt_clear, standby_reg, timeout_flag_reg, powerdown_flag_reg;
  idec_pkg::op_t op_reg;
  logic [6:0] file_addr_reg;
  logic [2:0] bit_sel_reg, flag_mask_reg;
  logic [10:0] target_reg;
  logic [15:0] rs = 16'h0031;
  logic [9:0] e;
  logic chk_on = 1'b0, prev_two = 1'b0, pst = 1'b1;
  int error_cnt = 0, samples_checked = 0, k = 0, gap = 0, ex_cnt = 0, cyc = 0, n;
  instruction_decode_execute i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .instr_word(instr_word),
    .file_data(file_data), .prescaler_to_timer(pst), .wake(wake), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fetch_strobe(fetch_strobe), .exec_strobe(exec_strobe),
    .op_reg(op_reg), .file_addr_reg(file_addr_reg), .dest_file_reg(dest_file_reg), .bit_sel_reg(bit_sel_reg),
    .literal_reg(literal_reg), .target_reg(target_reg), .flag_mask_reg(flag_mask_reg),
    .two_cycle_reg(two_cycle_reg), .nop_cycle_reg(nop_cycle_reg), .read_pins_reg(read_pins_reg),
    .prescaler_clear(prescaler_clear), .wdt_clear(wdt_clear), .standby_reg(standby_reg),
    .timeout_flag_reg(timeout_flag_reg), .powerdown_flag_reg(powerdown_flag_reg));
  prog_mem i_mem (.sys_clk(sys_clk), .arst_n(arst_n), .fetch_strobe(fetch_strobe), .ld_en(ld_en),
    .ld_addr(ld_addr), .ld_data(ld_data), .instr_word(instr_word), .file_data(file_data));
  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // expected {two cycles, {c, dc, z} mask, operation} of a word and its operand
  function automatic logic [9:0] exp_dec(input logic [13:0] x, input logic [7:0] f);
    casez (x[13:8])
      6'h00: begin
        if (x[7]) return {1'b0, MN, idec_pkg::op_move_accum_to_file};
        if ((x[7:0] & idec_pkg::CW_NOP_MASK) == 8'h00) return {1'b0, MN, idec_pkg::op_nop};
        case (x[7:0])
          idec_pkg::CW_RETURN: return {1'b1, MN, idec_pkg::op_return};
          idec_pkg::CW_RETURN_INT: return {1'b1, MN, idec_pkg::op_return_from_int};
          idec_pkg::CW_STANDBY: return {1'b0, MN, idec_pkg::op_standby};
          idec_pkg::CW_CLEAR_WDT: return {1'b0, MN, idec_pkg::op_clear_watchdog};
          default: return {1'b0, MN, idec_pkg::op_nop};
        endcase
      end
      6'h01: return x[7] ? {1'b0, MZ, idec_pkg::op_clear_file} : {1'b0, MZ, idec_pkg::op_clear_accum};
      6'h02: return {1'b0, MA, idec_pkg::op_file_minus_accum};
      6'h03: return {1'b0, MZ, idec_pkg::op_decrement_file};
      6'h04: return {1'b0, MZ, idec_pkg::op_or_accum_into_file};
      6'h05: return {1'b0, MZ, idec_pkg::op_and_accum_file};
      6'h06: return {1'b0, MZ, idec_pkg::op_exclusive_or_accum_file};
      6'h07: return {1'b0, MA, idec_pkg::op_add_accum_file};
      6'h08: return {1'b0, MZ, idec_pkg::op_move_file};
      6'h09: return {1'b0, MZ, idec_pkg::op_complement_file};
      6'h0a: return {1'b0, MZ, idec_pkg::op_increment_file};
      6'h0b: return {f == 8'h01, MN, idec_pkg::op_decrement_skip_zero};
      6'h0c: return {1'b0, MC, idec_pkg::op_rotate_right_via_carry};
      6'h0d: return {1'b0, MC, idec_pkg::op_rotate_left_via_carry};
      6'h0e: return {1'b0, MN, idec_pkg::op_swap_nibbles};
      6'h0f: return {f == 8'hff, MN, idec_pkg::op_increment_skip_zero};
      6'b0100??: return {1'b0, MN, idec_pkg::op_bit_clear};
      6'b0101??: return {1'b0, MN, idec_pkg::op_bit_set};
      6'b0110??: return {!f[x[9:7]], MN, idec_pkg::op_bit_test_skip_clear};
      6'b0111??: return {f[x[9:7]], MN, idec_pkg::op_bit_test_skip_set};
      6'b100???: return {1'b1, MN, idec_pkg::op_call};
      6'b101???: return {1'b1, MN, idec_pkg::op_jump_absolute};
      6'b1100??: return {1'b0, MN, idec_pkg::op_move_literal};
      6'b1101??: return {1'b1, MN, idec_pkg::op_return_with_literal};
      6'h38: return {1'b0, MZ, idec_pkg::op_or_literal_accum};
      6'h39: return {1'b0, MZ, idec_pkg::op_and_literal_accum};
      6'b11110?: return {1'b0, MA, idec_pkg::op_literal_minus_accum};
      6'b11111?: return {1'b0, MA, idec_pkg::op_add_literal_accum};
      default: return {1'b0, MN, idec_pkg::op_nop};
    endcase
  endfunction : exp_dec
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // single word transfer; address phase then data phase, each held until hready
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= idec_pkg::HTRANS_NONSEQ;
    hsel <= 1'b1;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    check(hresp, 1'b0);
    if (!wr) check(hrdata, d);
  endtask : ahb
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: every executed cycle up to standby compared against the expected decode
  always @(posedge sys_clk) begin
    cyc++;
    gap++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
    if (exec_strobe) ex_cnt++;
    if (chk_on && exec_strobe) begin
      cw = wq[k][13:0];
      e = prev_two ? {4'h0, idec_pkg::op_nop} : exp_dec(cw, wq[k][21:14]);
      if (k > 0) check(gap, idec_pkg::OSC_PER_CYCLE);
      check(op_reg, e[5:0]);
      check(nop_cycle_reg, prev_two);
      if (!prev_two) begin
        check(two_cycle_reg, e[9]);
        check(flag_mask_reg, e[8:6]);
        if (cw[13:12] == 2'h0 && cw[13:8] != 6'h00) check({dest_file_reg, file_addr_reg}, cw[7:0]);
        if (cw[13:12] == 2'h1) check({bit_sel_reg, file_addr_reg}, cw[9:0]);
        if (cw[13:12] == 2'h2) check(target_reg, cw[10:0]);
        if (cw[13:12] == 2'h3) check(literal_reg, cw[7:0]);
      end
      if (k == 0 || k == 12) check(prescaler_clear, k == 0);
      if (k == 11) pst <= 1'b0;
      if (k == 1) check(read_pins_reg, 1'b1);
      if (k == 2) check(wdt_clear, 1'b1);
      prev_two = prev_two ? 1'b0 : e[9];
      gap = 0;
      k++;
    end
  end
  // main sequence: preload, halted check, run, standby and wake
  initial begin
    for (int i = 0; i < 256; i++) begin
      rs = lfsr(rs);
      w = rs[13:0];
      rs = lfsr(rs);
      fd = rs[7:0];
      // keep random file writes away from timer and program counter
      if (!w[13] && (w[13:8] != 6'h00 || w[7])) w[3] = 1'b1;
      if (w[13:7] == 7'h02) w[6:0] = 7'h03;
      if (w[13:8] == 6'h00 && w[7:0] == 8'h63) w[7:0] = 8'h64;
      wq[i] = (i < 14) ? CORNER[i] : {fd, w};
    end
    wq[199] = 22'h0;
    wq[200] = 22'h000063;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(posedge sys_clk);
      ld_en <= 1'b1;
      ld_addr <= i[7:0];
      ld_data <= wq[i];
    end
    @(posedge sys_clk);
    ld_en <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check(ex_cnt, 0);
    chk_on = 1'b1;
    ahb(1'b1, 32'h10, 32'hff);
    ahb(1'b0, 32'h10, 32'h0);
    ahb(1'b1, idec_pkg::OFS_CTRL, 32'h1);
    ahb(1'b0, idec_pkg::OFS_CTRL, 32'h1);
    n = 0;
    while (standby_reg !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk); // let the monitor take the standby cycle first
    chk_on = 1'b0;
    check(k, 201);
    check({timeout_flag_reg, powerdown_flag_reg}, 2'h2);
    n = ex_cnt;
    repeat (20) @(posedge sys_clk);
    check(ex_cnt, n);
    ahb(1'b0, idec_pkg::OFS_STATUS, {20'h0, idec_pkg::op_standby, 6'h30});
    ahb(1'b0, idec_pkg::OFS_LAST, 32'h0000_0063);
    wake <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    wake <= 1'b0;
    check(standby_reg, 1'b0);
    repeat (12) @(posedge sys_clk);
    check(ex_cnt > n, 1'b1);
    close_out();
  end
endmodule : instruction_decode_execute_tb
